// *** design/lsfs_pkg.sv ***
// Package for the LED sink fault supervisor: constants, types and rule summary.
// Function
// R1 - Grounded sinks found at start are excluded
// R2 - Sink on/off follows synchronized dimming PWM
// R3 - Converter target uses 256-step scale
// R4 - Periodic downward nudge of target
// R5 - Three headroom comparators per sink, filtered 1us
// R6 - All sinks inside window: hold target
// R7 - All sinks above middle: decrement target
// R8 - Any sink below low: increment target
// R9 - Target at max, sink low: open fault
// R10 - Sink above high, another in window: short
// R11 - Other faults enter retry, all off
// R12 - Retry lasts 100 ms, then recovers
// R13 - String faults keep running, flag asserted
// R14 - Enable low 2-20 us clears flag
// R15 - Longer enable low enters idle wait
// R16 - Input overvoltage filtered 100 us
// R17 - Output overvoltage filter 560/50 ms, 160 ms
// R18 - Undervoltage filtered 100 us in every state
// R19 - Overtemperature forces retry until cleared
// R20 - Enable high leaves idle wait and starts
// R21 - Timers on local clock, pins synchronized
package lsfs_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int NSINK = 4;
  localparam int FILT_NS = 1000;
  localparam int FILT_CYC = (FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CLRMIN_NS = 2000;
  localparam int CLRMIN_CYC = (CLRMIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CLRMAX_NS = 20000;
  localparam int CLRMAX_CYC = CLRMAX_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int SUPF_US = 100;
  localparam int SUPF_CYC = SUPF_US * (CLK_HZ / 1_000_000);
  localparam int RETRY_MS = 100;
  localparam int OVLONG_MS = 560;
  localparam int OVSHORT_MS = 50;
  localparam int OVREARM_MS = 160;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int NUDGE_US = 100;
  localparam int NUDGE_CYC = NUDGE_US * (CLK_HZ / 1_000_000);
  localparam int SENSE_CYC = 16;
  localparam logic [7:0] TGT_MAX = 8'hff;
  localparam logic [7:0] TGT_INIT = 8'he1;
  typedef enum logic [2:0] {
    LSFS_IDLE = 3'b000,
    LSFS_SENSE = 3'b001,
    LSFS_ACTIVE = 3'b011,
    LSFS_RETRY = 3'b010
  } lsfs_state_t;
  typedef struct packed {
    logic [NSINK-1:0] low;
    logic [NSINK-1:0] mid;
    logic [NSINK-1:0] high;
  } lsfs_cmp_t;
  typedef struct packed {
    logic string_open_flag;
    logic string_shorted_flag;
    logic supply_overvoltage_flag;
    logic out_overvoltage;
    logic supply_undervoltage_flag;
    logic overtemp_flag;
  } lsfs_flags_t;
endpackage : lsfs_pkg

// *** design/lsfs_top.sv ***
// Supervisor state machine, headroom adaptation and fault filtering.
`timescale 1ns/10ps
module lsfs_top #(
  parameter int RETRY_CYC = lsfs_pkg::RETRY_MS * lsfs_pkg::CYC_PER_MS,
  parameter int OVLONG_CYC = lsfs_pkg::OVLONG_MS * lsfs_pkg::CYC_PER_MS,
  parameter int OVSHORT_CYC = lsfs_pkg::OVSHORT_MS * lsfs_pkg::CYC_PER_MS,
  parameter int OVREARM_CYC = lsfs_pkg::OVREARM_MS * lsfs_pkg::CYC_PER_MS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic supply_enable_pin,
  input wire logic pwm_pin,
  input wire logic [lsfs_pkg::NSINK-1:0] sink_grounded,
  input wire lsfs_pkg::lsfs_cmp_t cmp_raw,
  input wire logic vin_over_raw,
  input wire logic vout_over_raw,
  input wire logic vin_under_raw,
  input wire logic overtemp_raw,
  output logic [lsfs_pkg::NSINK-1:0] sink_on,
  output logic converter_en,
  output logic [7:0] target_code,
  output logic fault_pin_o,
  output logic fault_pin_oe,
  output lsfs_pkg::lsfs_flags_t flags,
  output lsfs_pkg::lsfs_state_t state
);
  import lsfs_pkg::*;

  // ----------------------------------------
  // State record
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] en_s;
    logic [1:0] pwm_s;
    logic [1:0] ovi_s;
    logic [1:0] ovo_s;
    logic [1:0] uv_s;
    logic [1:0] ot_s;
    logic [3*NSINK-1:0] cmp_s1;
    logic [3*NSINK-1:0] cmp_s2;
    logic [3*NSINK-1:0] cmp_f;
    logic [3*NSINK*5-1:0] cmp_cnt;
    logic [NSINK-1:0] gnd_s1;
    logic [NSINK-1:0] gnd_s2;
    lsfs_state_t st;
    logic [NSINK-1:0] live;
    logic [NSINK-1:0] on;
    logic [7:0] tgt;
    logic [31:0] tmr;
    logic [15:0] nudge;
    logic [15:0] enlow;
    logic [11:0] ovi_cnt;
    logic [11:0] uv_cnt;
    logic [31:0] ovo_cnt;
    logic [31:0] act_cnt;
    logic short_filt;
    lsfs_flags_t fl;
  } lsfs_regs_t;

  lsfs_regs_t r_q;
  lsfs_regs_t r_d;

  logic [NSINK-1:0] f_low;
  logic [NSINK-1:0] f_mid;
  logic [NSINK-1:0] f_high;
  logic [NSINK-1:0] in_win;
  logic [NSINK-1:0] below;
  logic [NSINK-1:0] shorted;
  logic sys_fault;
  logic ovi_hit;
  logic uv_hit;
  logic ovo_hit;

  // Comparator outputs are one when the sink voltage lies above that level.
  // The first struct member sits in the top bits of the packed word.
  assign f_low = r_q.cmp_f[3*NSINK-1:2*NSINK];
  assign f_mid = r_q.cmp_f[2*NSINK-1:NSINK];
  assign f_high = r_q.cmp_f[NSINK-1:0];
  assign in_win = r_q.live & f_low & ~f_mid;
  assign below = r_q.live & ~f_low;
  assign shorted = (|in_win) ? (r_q.live & f_high & ~in_win) : '0; // R10

  // ----------------------------------------
  // Main next-state logic
  // ----------------------------------------
  always_comb begin
    r_d.en_s = {r_q.en_s[0], supply_enable_pin}; // R21
    r_d.pwm_s = {r_q.pwm_s[0], pwm_pin}; // R21
    r_d.ovi_s = {r_q.ovi_s[0], vin_over_raw};
    r_d.ovo_s = {r_q.ovo_s[0], vout_over_raw};
    r_d.uv_s = {r_q.uv_s[0], vin_under_raw};
    r_d.ot_s = {r_q.ot_s[0], overtemp_raw};
    r_d.cmp_s1 = cmp_raw; // R5
    r_d.cmp_s2 = r_q.cmp_s1;
    r_d.gnd_s1 = sink_grounded; // R21
    r_d.gnd_s2 = r_q.gnd_s1;
    // Each comparator output is accepted only after it has stood steady for the filter time.
    for (int i = 0; i < 3 * NSINK; i++) begin
      r_d.cmp_f[i] = r_q.cmp_f[i];
      if (r_q.cmp_s2[i] == r_q.cmp_f[i]) begin
        r_d.cmp_cnt[5*i+:5] = 5'h00;
      end else if (r_q.cmp_cnt[5*i+:5] >= 5'(FILT_CYC - 1)) begin
        r_d.cmp_f[i] = r_q.cmp_s2[i]; // R5
        r_d.cmp_cnt[5*i+:5] = 5'h00;
      end else begin
        r_d.cmp_cnt[5*i+:5] = r_q.cmp_cnt[5*i+:5] + 5'h01;
      end
    end
    r_d.st = r_q.st;
    r_d.live = r_q.live;
    r_d.tgt = r_q.tgt;
    r_d.tmr = r_q.tmr;
    r_d.nudge = r_q.nudge;
    r_d.fl = r_q.fl;
    r_d.short_filt = r_q.short_filt;
    r_d.act_cnt = r_q.act_cnt;

    // Undervoltage is watched everywhere; input overvoltage and heat outside idle, output overvoltage only while active.
    r_d.uv_cnt = r_q.uv_s[1] ? ((r_q.uv_cnt < 12'(SUPF_CYC)) ? r_q.uv_cnt + 12'h1 : r_q.uv_cnt)
                             : 12'h0;
    uv_hit = r_q.uv_cnt >= 12'(SUPF_CYC); // R18
    r_d.ovi_cnt = (r_q.ovi_s[1] && r_q.st != LSFS_IDLE) ?
                  ((r_q.ovi_cnt < 12'(SUPF_CYC)) ? r_q.ovi_cnt + 12'h1 : r_q.ovi_cnt) : 12'h0;
    ovi_hit = r_q.ovi_cnt >= 12'(SUPF_CYC); // R16
    r_d.ovo_cnt = (r_q.ovo_s[1] && r_q.st == LSFS_ACTIVE) ? r_q.ovo_cnt + 32'h1 : 32'h0;
    ovo_hit = r_q.ovo_cnt >= (r_q.short_filt ? 32'(OVSHORT_CYC) : 32'(OVLONG_CYC)); // R17
    sys_fault = uv_hit || ((ovi_hit || ovo_hit || r_q.ot_s[1]) && r_q.st != LSFS_IDLE);

    // Enable-low width measurement, saturating just past the clear window.
    r_d.enlow = r_q.en_s[1] ? 16'h0 :
                ((r_q.enlow <= 16'(CLRMAX_CYC)) ? r_q.enlow + 16'h1 : r_q.enlow);

    case (r_q.st)
      LSFS_IDLE: begin
        r_d.fl = '0;
        r_d.live = '0;
        r_d.tmr = 32'h0;
        if (r_q.en_s[1] && !uv_hit) begin
          r_d.st = LSFS_SENSE; // R20
          r_d.tgt = TGT_INIT;
        end
      end
      LSFS_SENSE: begin
        r_d.tmr = r_q.tmr + 32'h1;
        if (r_q.tmr >= 32'(SENSE_CYC - 1)) begin
          r_d.live = ~r_q.gnd_s2; // R1
          r_d.st = LSFS_ACTIVE;
          r_d.tmr = 32'h0;
          r_d.act_cnt = 32'h0;
        end
      end
      LSFS_ACTIVE: begin
        r_d.nudge = (r_q.nudge >= 16'(NUDGE_CYC - 1)) ? 16'h0 : r_q.nudge + 16'h1;
        if (|below) begin
          if (r_q.tgt == TGT_MAX) begin
            r_d.live = r_q.live & ~below; // R9
            r_d.fl.string_open_flag = 1'b1; // R9
          end else begin
            r_d.tgt = r_q.tgt + 8'h01; // R8
          end
        end else if (&(f_mid | ~r_q.live) && (|r_q.live)) begin
          if (r_q.tgt != 8'h00) begin
            r_d.tgt = r_q.tgt - 8'h01; // R7
          end
        end else if (r_q.nudge == 16'h0 && r_q.tgt != 8'h00) begin
          r_d.tgt = r_q.tgt - 8'h01; // R4
        end
        // With every sink inside the window only the periodic nudge moves the target. R6
        if (|shorted) begin
          r_d.live = r_d.live & ~shorted; // R10
          r_d.fl.string_shorted_flag = 1'b1; // R13
        end
        r_d.act_cnt = (r_q.act_cnt < 32'(OVREARM_CYC)) ? r_q.act_cnt + 32'h1 : r_q.act_cnt;
        if (r_q.act_cnt >= 32'(OVREARM_CYC)) begin
          r_d.short_filt = 1'b0; // R17
        end
        // A short enable-low pulse clears string flags; events that cycle still win.
        if (r_q.en_s[1] && r_q.enlow >= 16'(CLRMIN_CYC) && r_q.enlow <= 16'(CLRMAX_CYC)) begin
          r_d.fl.string_open_flag = (|below) && r_q.tgt == TGT_MAX; // R14
          r_d.fl.string_shorted_flag = |shorted; // R14
        end
        if (r_q.enlow > 16'(CLRMAX_CYC)) begin
          r_d.st = LSFS_IDLE; // R15
        end else if (sys_fault) begin
          r_d.st = LSFS_RETRY; // R11
          r_d.tmr = 32'h0;
          if (ovo_hit) begin
            r_d.short_filt = 1'b1; // R17
          end
        end
      end
      LSFS_RETRY: begin
        r_d.tmr = (r_q.tmr < 32'(RETRY_CYC)) ? r_q.tmr + 32'h1 : r_q.tmr;
        if (r_q.enlow > 16'(CLRMAX_CYC)) begin
          r_d.st = LSFS_IDLE; // R15
        end else if (r_q.tmr >= 32'(RETRY_CYC) && !sys_fault && !r_q.ovo_s[1]) begin
          r_d.st = LSFS_ACTIVE; // R12
          r_d.tgt = TGT_INIT;
          r_d.act_cnt = 32'h0;
        end
      end
      default: begin
        r_d.st = LSFS_IDLE;
      end
    endcase

    r_d.fl.supply_undervoltage_flag = uv_hit;
    r_d.fl.supply_overvoltage_flag = ovi_hit;
    r_d.fl.out_overvoltage = ovo_hit;
    r_d.fl.overtemp_flag = r_q.ot_s[1] && r_q.st != LSFS_IDLE; // R19

    // LEDs follow PWM only while active, enable high and the sink still live.
    r_d.on = (r_d.st == LSFS_ACTIVE && r_q.en_s[1] && r_q.pwm_s[1]) ? r_d.live : '0; // R2
  end

  // ----------------------------------------
  // Registers and outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      r_q <= '0;
      r_q.st <= LSFS_IDLE;
      sink_on <= '0;
      converter_en <= 1'b0;
      target_code <= 8'h00;
      fault_pin_oe <= 1'b0;
      fault_pin_o <= 1'b0;
      flags <= '0;
      state <= LSFS_IDLE;
    end else begin
      r_q <= r_d;
      sink_on <= r_d.on;
      converter_en <= r_d.st == LSFS_SENSE || r_d.st == LSFS_ACTIVE; // R11
      target_code <= r_d.tgt; // R3
      fault_pin_o <= 1'b0;
      fault_pin_oe <= r_d.st == LSFS_RETRY || r_d.fl.string_open_flag ||
                      r_d.fl.string_shorted_flag; // R13
      flags <= r_d.fl;
      state <= r_d.st;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_retry_all_off: assert property (@(posedge clk) disable iff (reset) // R11
    state == LSFS_RETRY |-> sink_on == '0 && !converter_en && fault_pin_oe)
    else $error("Retry state with outputs still on.");
  a_string_flag_pin: assert property (@(posedge clk) disable iff (reset) // R13
    (flags.string_open_flag || flags.string_shorted_flag) |-> fault_pin_oe)
    else $error("String fault without fault pin.");
  a_up_step: assert property (@(posedge clk) disable iff (reset) // R8
    (r_q.st == LSFS_ACTIVE && r_d.st == LSFS_ACTIVE && |below && r_q.tgt != TGT_MAX)
    |=> target_code == $past(r_q.tgt) + 8'h01)
    else $error("Target did not step up.");
  a_open_at_max: assert property (@(posedge clk) disable iff (reset) // R9
    (r_q.st == LSFS_ACTIVE && |below && r_q.tgt == TGT_MAX) |=> flags.string_open_flag)
    else $error("Open string not flagged.");
  a_grounded_excl: assert property (@(posedge clk) disable iff (reset) // R1
    (r_q.st == LSFS_SENSE && r_d.st == LSFS_ACTIVE) |=> (r_q.live & $past(r_q.gnd_s2)) == '0)
    else $error("Grounded sink left live.");
  a_pwm_follow: assert property (@(posedge clk) disable iff (reset) // R2
    (state == LSFS_ACTIVE && !r_q.pwm_s[1]) |=> sink_on == '0)
    else $error("Sink on while PWM low.");
  a_uv_filter: assert property (@(posedge clk) disable iff (reset) // R18
    $rose(r_q.uv_s[1]) |-> !flags.supply_undervoltage_flag [*8])
    else $error("Undervoltage flagged too early.");
  a_idle_wait: assert property (@(posedge clk) disable iff (reset) // R15
    (r_q.st == LSFS_ACTIVE && r_q.enlow > 16'(CLRMAX_CYC)) |=> state == LSFS_IDLE)
    else $error("Long enable low did not idle.");
  a_retry_wait: assert property (@(posedge clk) disable iff (reset) // R12
    (state == LSFS_RETRY && r_q.tmr < 32'(RETRY_CYC)) |=> state != LSFS_ACTIVE)
    else $error("Retry left early.");
endmodule : lsfs_top

// *** sim/lsfs_host.sv ***
// Host controller model driving the enable pin and the dimming PWM.
`timescale 1ns/10ps
module lsfs_host #(
  parameter int PWM_HALF = 500
) (
  input wire logic clk,
  output logic supply_enable_pin,
  output logic pwm_pin
);
  int pwm_cnt = 0;
  initial supply_enable_pin = 1'b0;
  initial pwm_pin = 1'b0;
  // ------------------------------------------------------------
  // Dimming PWM
  // ------------------------------------------------------------
  // The fastest legal rate is used so that every scenario sees many edges.
  always @(posedge clk) begin
    pwm_cnt <= (pwm_cnt == PWM_HALF - 1) ? 0 : pwm_cnt + 1;
    if (pwm_cnt == PWM_HALF - 1) begin
      pwm_pin <= ~pwm_pin;
    end
  end
  // ------------------------------------------------------------
  // Enable pin
  // ------------------------------------------------------------
  task automatic set_en(input logic v);
    @(posedge clk);
    supply_enable_pin <= v;
  endtask : set_en
endmodule : lsfs_host

// *** sim/lsfs_tb_top.sv ***
// Self-checking testbench for the LED sink fault supervisor.
`timescale 1ns/10ps
`define CHK(a, b) check((a) === (b))
module lsfs_tb_top;
  import lsfs_pkg::*;
  localparam int RET = 1000;
  localparam int OVL = 1500;
  localparam int OVS = 500;
  localparam int OVR = 800;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [NSINK-1:0] gnd = 4'b1000;
  lsfs_cmp_t cmp = '0;
  logic [3:0] fr = 4'h0;
  logic en_pin;
  logic pwm;
  logic [NSINK-1:0] sink_on;
  logic conv_en;
  logic [7:0] tgt;
  logic f_o;
  logic f_oe;
  lsfs_flags_t flags;
  lsfs_state_t state;
  logic [7:0] t0;
  int num_errors = 0;
  int num_checks = 0;
  int n;
  always #25 clk = ~clk;
  lsfs_host lsfs_host_inst (.clk(clk), .supply_enable_pin(en_pin), .pwm_pin(pwm));
  lsfs_top #(.RETRY_CYC(RET), .OVLONG_CYC(OVL), .OVSHORT_CYC(OVS), .OVREARM_CYC(OVR))
  lsfs_top_inst (.clk(clk), .reset(reset), .supply_enable_pin(en_pin), .pwm_pin(pwm),
    .sink_grounded(gnd), .cmp_raw(cmp), .vin_over_raw(fr[0]), .vout_over_raw(fr[1]),
    .vin_under_raw(fr[2]), .overtemp_raw(fr[3]), .sink_on(sink_on), .converter_en(conv_en),
    .target_code(tgt), .fault_pin_o(f_o), .fault_pin_oe(f_oe), .flags(flags), .state(state));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic ok);
    num_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t: output differs from expected", $time);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wait_state(input lsfs_state_t s, input int lim);
    n = 0;
    while (state !== s && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_state
  task automatic setc(input logic [11:0] v);
    @(posedge clk);
    cmp <= v;
  endtask : setc
  task automatic pwm_chk(input logic [NSINK-1:0] live);
    @(posedge pwm);
    cyc(10);
    `CHK(sink_on, live);
  endtask : pwm_chk
  // Raise one fault input, time the entry to retry, then release and wait for recovery.
  task automatic fault(input int sel, input int lo, input int hi, input logic hold);
    @(posedge clk);
    fr[sel] <= 1'b1;
    wait_state(LSFS_RETRY, hi);
    `CHK(n >= lo && n < hi, 1'b1);
    cyc(2);
    `CHK({conv_en, sink_on, f_oe}, 6'b000001);
    if (hold) begin
      cyc(RET + 20);
      `CHK(state, LSFS_RETRY);
    end
    @(posedge clk);
    fr[sel] <= 1'b0;
    wait_state(LSFS_ACTIVE, RET + 60);
    cyc(2);
    `CHK({state, f_oe}, {LSFS_ACTIVE, 1'b0});
  endtask : fault
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h7b403594));
    cyc(2);
    `CHK({state, conv_en, sink_on, tgt, f_oe, f_o, flags}, 24'h0);
    @(posedge clk);
    reset <= 1'b0;
    setc({4'b0111, 4'b0000, 4'b0000});
    lsfs_host_inst.set_en(1'b1);
    wait_state(LSFS_SENSE, 10);
    `CHK({conv_en, tgt}, {1'b1, TGT_INIT});
    wait_state(LSFS_ACTIVE, SENSE_CYC + 4);
    pwm_chk(4'b0111);
    t0 = tgt;
    cyc(100);
    `CHK(8'(t0 - tgt) <= 8'h01, 1'b1);
    cyc(NUDGE_CYC);
    `CHK(8'(t0 - tgt) inside {8'h01, 8'h02}, 1'b1);
    setc({4'b0111, 4'b0111, 4'b0000});
    cyc(25);
    t0 = tgt;
    cyc(20);
    `CHK(8'(t0 - tgt), 8'h14);
    setc({4'b0110, 4'b0000, 4'b0000});
    cyc(25);
    t0 = tgt;
    cyc(20);
    `CHK(8'(tgt - t0), 8'h14);
    cyc(300);
    // A periodic nudge may already have taken one step off the maximum.
    `CHK({tgt >= 8'hfe, flags.string_open_flag, f_oe, state}, {3'b111, LSFS_ACTIVE});
    pwm_chk(4'b0110);
    setc({4'b0111, 4'b0000, 4'b0000});
    lsfs_host_inst.set_en(1'b0);
    cyc(20);
    `CHK({sink_on, state}, {4'h0, LSFS_ACTIVE});
    cyc(20 + $urandom % 300);
    lsfs_host_inst.set_en(1'b1);
    cyc(10);
    `CHK({flags, f_oe}, 7'h00);
    setc({4'b0111, 4'b0010, 4'b0010});
    cyc(30);
    `CHK({flags.string_shorted_flag, sink_on[1], f_oe}, 3'b101);
    lsfs_host_inst.set_en(1'b0);
    cyc(CLRMAX_CYC + 100);
    `CHK(state, LSFS_IDLE);
    setc({4'b0111, 4'b0000, 4'b0000});
    cyc(30);
    lsfs_host_inst.set_en(1'b1);
    wait_state(LSFS_ACTIVE, SENSE_CYC + 10);
    `CHK({state, flags}, {LSFS_ACTIVE, 6'h00});
    fault(2, SUPF_CYC - 5, SUPF_CYC + 10, 1'b1);
    fault(0, SUPF_CYC - 5, SUPF_CYC + 10, 1'b1);
    fault(3, 0, 10, 1'b1);
    cyc(OVR + 50);
    fault(1, OVL - 5, OVL + 10, 1'b0);
    fault(1, OVS - 5, OVS + 10, 1'b0);
    cyc(OVR + 50);
    fault(1, OVL - 5, OVL + 10, 1'b0);
    summarize();
  end
  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    summarize();
  end
endmodule : lsfs_tb_top
